// >>> core/hpc_pkg.sv
package hpc_pkg;
  // Endpoint count and hub address width.
  localparam int unsigned NUM_EP     = 8;
  localparam int unsigned EP_W       = 3;
  localparam int unsigned HUB_W      = 7;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PWRCFG   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PWRCMD   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_REQ      = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PEND     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_HUB_BASE = 8'h40;

  // Hub address window: bit 5 selects OUT(1)/IN(0), bits 4:2 the endpoint.
  localparam int unsigned HUB_DIR_BIT = 5;
  localparam int unsigned HUB_EP_LSB  = 2;

  // Power configuration fields.
  localparam int unsigned CFG_FLT_HIGH_BIT = 0;
  localparam int unsigned CFG_ACT_LSB      = 1;
  localparam int unsigned CFG_AUTO_BIT     = 3;
  localparam int unsigned CFG_EN_HIGH_BIT  = 4;
  localparam int unsigned CFG_FILTER_BIT   = 5;
  localparam int unsigned CFG_W            = 6;

  // Power command bits (write one to act).
  localparam int unsigned CMD_SUPPLY_ON  = 0;
  localparam int unsigned CMD_SUPPLY_OFF = 1;
  localparam int unsigned CMD_FAULT_ON   = 2;
  localparam int unsigned CMD_FAULT_OFF  = 3;
  localparam int unsigned CMD_SESS_ON    = 4;
  localparam int unsigned CMD_SESS_OFF   = 5;

  // Request register: bit 8 status request, bit 7 IN request, 2:0 endpoint.
  localparam int unsigned REQ_STATUS_BIT = 8;
  localparam int unsigned REQ_IN_BIT     = 7;

  // Interrupt status bits.
  localparam int unsigned IRQ_FAULT  = 0;
  localparam int unsigned IRQ_STATUS = 1;
  localparam int unsigned IRQ_INDATA = 2;
  localparam int unsigned IRQ_W      = 3;

  // Fault actions.
  typedef enum logic [1:0] {
    fault_action_none       = 2'h0,
    fault_action_hiz        = 2'h1,
    fault_action_drive_low  = 2'h2,
    fault_action_drive_high = 2'h3
  } fault_action_type;

  // Glitch filter: a bus-voltage dip shorter than this is ignored.
  localparam int unsigned FILTER_NS     = 1000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FILTER_CYC    = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W        = 4;

  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
endpackage

// >>> core/hpc_txn_if.sv
interface hpc_txn_if;
  import hpc_pkg::*;
  logic            start;
  logic            is_status;
  logic [EP_W-1:0]  ep;
  logic [HUB_W-1:0] hub;
  logic            busy;
  logic            done;
  modport ctrl (output start, output is_status, output ep, output hub,
                input busy, input done);
  modport seq  (input start, input is_status, input ep, input hub,
                output busy, output done);
endinterface

// >>> core/hpc_txn_seq.sv
// Runs one IN token toward the device and waits for its data or status packet.
module hpc_txn_seq
  import hpc_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Controller side.
  hpc_txn_if.seq          txn,
  // Bus side.
  output logic            tok_valid,
  output logic [EP_W-1:0]  tok_ep,
  output logic [HUB_W-1:0] tok_hub,
  output logic            tok_status,
  input  wire logic       pkt_rcvd
);
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_tok  = 3'b010,
    st_wait = 3'b100
  } seq_state_type;

  seq_state_type    state_q, state_d;
  logic [EP_W-1:0]  ep_q, ep_d;
  logic [HUB_W-1:0] hub_q, hub_d;
  logic             sts_q, sts_d;

  // Next-state logic; the request is captured so software may reprogram meanwhile.
  always_comb begin
    state_d = state_q;
    ep_d    = ep_q;
    hub_d   = hub_q;
    sts_d   = sts_q;
    case (state_q)
      st_idle: begin
        if (txn.start) begin
          ep_d    = txn.ep;
          hub_d   = txn.hub;
          sts_d   = txn.is_status;
          state_d = st_tok;
        end
      end
      st_tok:  state_d = st_wait;
      st_wait: begin
        if (pkt_rcvd) begin
          state_d = st_idle;
        end
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= st_idle;
      ep_q    <= '0;
      hub_q   <= '0;
      sts_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ep_q    <= ep_d;
      hub_q   <= hub_d;
      sts_q   <= sts_d;
    end
  end

  assign tok_valid  = (state_q == st_tok);
  assign tok_ep     = ep_q;
  assign tok_hub    = hub_q;
  assign tok_status = sts_q;
  assign txn.busy   = (state_q != st_idle);
  assign txn.done   = (state_q == st_wait) && pkt_rcvd;
endmodule

// >>> core/hpc_ctrl.sv
// Notes on behaviour
// - Per-endpoint hub address, IN and OUT, readable.
// - Writes load hub address; transfers use it.
// - Mode control switches controller to host role.
// - Fault input polarity is selectable low/high.
// - Fault applies chosen supply-enable action.
// - Manual mode: enable command drives active level.
// - Auto mode: session enable drives active level.
// - Optional glitch filter ignores short voltage dips.
// - Enable/disable commands switch supply output.
// - Disabled fault detection causes no action.
// - IN request schedules an IN transaction.
// - Status request issues endpoint-zero status IN.
// - Status request only on endpoint zero.
// - Received status packet raises an interrupt.
//
// Added by the designer: the strobed register port and the register offsets.
module hpc_ctrl
  import hpc_pkg::*;
(
  // Clock and reset.
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // Register port.
  input  wire logic [hpc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [hpc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [hpc_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt.
  output logic                       irq,
  // Power pins.
  input  wire logic                  power_fault_input,
  input  wire logic                  bus_voltage_low,
  output logic                       supply_enable_output,
  output logic                       supply_enable_oe,
  output logic                       bus_voltage_err,
  // Token path toward the attached device.
  output logic                       tok_valid,
  output logic [hpc_pkg::EP_W-1:0]   tok_ep,
  output logic [hpc_pkg::HUB_W-1:0]  tok_hub,
  output logic                       tok_status,
  input  wire logic                  pkt_rcvd,
  // Host role indication.
  output logic                       host_mode
);
  import hpc_pkg::*;

  // Register byte address to endpoint index in the hub window.
  function automatic logic [EP_W-1:0] hub_ep(input logic [ADDR_W-1:0] a);
    return a[HUB_EP_LSB +: EP_W];
  endfunction

  function automatic logic in_hub_win(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:HUB_DIR_BIT+1] == OFS_HUB_BASE[ADDR_W-1:HUB_DIR_BIT+1])
           && (a[1:0] == 2'h0);
  endfunction

  logic [HUB_W-1:0]  hub_in_q [NUM_EP];
  logic [HUB_W-1:0]  hub_in_d [NUM_EP];
  logic [HUB_W-1:0]  hub_out_q [NUM_EP];
  logic [HUB_W-1:0]  hub_out_d [NUM_EP];
  logic              host_q, host_d;
  logic [CFG_W-1:0]  cfg_q, cfg_d;
  logic              sup_on_q, sup_on_d;
  logic              flt_en_q, flt_en_d;
  logic              sess_q, sess_d;
  logic [NUM_EP-1:0] pend_q, pend_d;
  logic              pend_sts_q, pend_sts_d;
  logic [EP_W-1:0]   cur_ep_q, cur_ep_d;
  logic [IRQ_W-1:0]  stat_q, stat_d;
  logic [IRQ_W-1:0]  mask_q, mask_d;
  logic [FILT_W-1:0] filt_q, filt_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  hpc_txn_if txn ();

  hpc_txn_seq u_seq (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .txn        (txn.seq),
    .tok_valid  (tok_valid),
    .tok_ep     (tok_ep),
    .tok_hub    (tok_hub),
    .tok_status (tok_status),
    .pkt_rcvd   (pkt_rcvd)
  );

  // Hub address storage, one register per endpoint and direction.
  generate
    for (genvar g = 0; g < NUM_EP; g++) begin : g_hub
      always_comb begin
        hub_in_d[g]  = hub_in_q[g];
        hub_out_d[g] = hub_out_q[g];
        if (reg_wr && in_hub_win(reg_addr) && hub_ep(reg_addr) == EP_W'(g)) begin
          if (reg_addr[HUB_DIR_BIT]) begin
            hub_out_d[g] = reg_wdata[HUB_W-1:0];
          end else begin
            hub_in_d[g]  = reg_wdata[HUB_W-1:0];
          end
        end
      end
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          hub_in_q[g]  <= '0;
          hub_out_q[g] <= '0;
        end else begin
          hub_in_q[g]  <= hub_in_d[g];
          hub_out_q[g] <= hub_out_d[g];
        end
      end
    end
  endgenerate

  // Fault sense: polarity select then enable gate.
  logic fault_raw;
  logic fault_evt;
  logic filt_dip;
  assign fault_raw = cfg_q[CFG_FLT_HIGH_BIT] ? power_fault_input
                                             : !power_fault_input;
  assign fault_evt = flt_en_q && host_q && fault_raw;

  // Glitch filter: a dip only counts once it has lasted FILTER_CYC cycles.
  assign filt_dip = bus_voltage_low && (filt_q == FILT_W'(FILTER_CYC));
  assign bus_voltage_err = cfg_q[CFG_FILTER_BIT] ? filt_dip : bus_voltage_low;

  // Scheduler: status request has priority, then lowest pending endpoint.
  logic        pick_any;
  logic [EP_W-1:0] pick_ep;
  always_comb begin
    pick_any = 1'b0;
    pick_ep  = '0;
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        pick_any = 1'b1;
        pick_ep  = EP_W'(i);
      end
    end
  end

  logic launch_sts;
  logic launch_in;
  assign launch_sts      = host_q && pend_sts_q && !txn.busy;
  assign launch_in       = host_q && !pend_sts_q && pick_any && !txn.busy;
  assign txn.start       = launch_sts || launch_in;
  assign txn.is_status   = launch_sts;
  assign txn.ep          = launch_sts ? '0 : pick_ep;
  assign txn.hub         = launch_sts ? hub_in_q[0] : hub_in_q[pick_ep];

  // Control registers, commands, scheduler and interrupt status.
  logic [IRQ_W-1:0] evt;
  always_comb begin
    host_d     = host_q;
    cfg_d      = cfg_q;
    sup_on_d   = sup_on_q;
    flt_en_d   = flt_en_q;
    sess_d     = sess_q;
    pend_d     = pend_q;
    pend_sts_d = pend_sts_q;
    cur_ep_d   = cur_ep_q;
    mask_d     = mask_q;
    stat_d     = stat_q;
    filt_d     = bus_voltage_low ? (filt_dip ? filt_q : filt_q + FILT_W'(1)) : '0;
    evt        = '0;
    if (reg_wr) begin
      case (reg_addr)
        OFS_MODE:     host_d = reg_wdata[0];
        OFS_PWRCFG:   cfg_d  = reg_wdata[CFG_W-1:0];
        OFS_PWRCMD: begin
          if (reg_wdata[CMD_SUPPLY_ON])  sup_on_d = 1'b1;
          if (reg_wdata[CMD_SUPPLY_OFF]) sup_on_d = 1'b0;
          if (reg_wdata[CMD_FAULT_ON])   flt_en_d = 1'b1;
          if (reg_wdata[CMD_FAULT_OFF])  flt_en_d = 1'b0;
          if (reg_wdata[CMD_SESS_ON])    sess_d   = 1'b1;
          if (reg_wdata[CMD_SESS_OFF])   sess_d   = 1'b0;
        end
        OFS_REQ: begin
          if (reg_wdata[REQ_STATUS_BIT]) pend_sts_d = 1'b1;
          if (reg_wdata[REQ_IN_BIT]) begin
            pend_d[reg_wdata[EP_W-1:0]] = 1'b1;
          end
        end
        OFS_IRQ_STAT: stat_d = stat_q & ~reg_wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: mask_d = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (launch_sts) begin
      pend_sts_d = 1'b0;
    end
    if (launch_in) begin
      pend_d[pick_ep] = 1'b0;
      cur_ep_d        = pick_ep;
    end
    if (!host_q) begin
      pend_d     = '0;
      pend_sts_d = 1'b0;
    end
    evt[IRQ_FAULT]  = fault_evt;
    evt[IRQ_STATUS] = txn.done && tok_status;
    evt[IRQ_INDATA] = txn.done && !tok_status;
    // Set wins over a clear written in the same cycle.
    stat_d = stat_d | evt;
    rdata_d = '0;
    if (reg_rd) begin
      if (in_hub_win(reg_addr)) begin
        rdata_d[HUB_W-1:0] = reg_addr[HUB_DIR_BIT] ? hub_out_q[hub_ep(reg_addr)]
                                                   : hub_in_q[hub_ep(reg_addr)];
      end else begin
        case (reg_addr)
          OFS_MODE:     rdata_d[0] = host_q;
          OFS_PWRCFG:   rdata_d[CFG_W-1:0] = cfg_q;
          OFS_PWRCMD:   rdata_d[2:0] = {sess_q, flt_en_q, sup_on_q};
          OFS_REQ:      rdata_d[EP_W-1:0] = cur_ep_q;
          OFS_PEND:     rdata_d[NUM_EP:0] = {pend_sts_q, pend_q};
          OFS_IRQ_STAT: rdata_d[IRQ_W-1:0] = stat_q;
          OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
          default:      rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_q     <= 1'b0;
      cfg_q      <= CFG_RESET;
      sup_on_q   <= 1'b0;
      flt_en_q   <= 1'b0;
      sess_q     <= 1'b0;
      pend_q     <= '0;
      pend_sts_q <= 1'b0;
      cur_ep_q   <= '0;
      stat_q     <= '0;
      mask_q     <= '0;
      filt_q     <= '0;
      rdata_q    <= '0;
    end else begin
      host_q     <= host_d;
      cfg_q      <= cfg_d;
      sup_on_q   <= sup_on_d;
      flt_en_q   <= flt_en_d;
      sess_q     <= sess_d;
      pend_q     <= pend_d;
      pend_sts_q <= pend_sts_d;
      cur_ep_q   <= cur_ep_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      filt_q     <= filt_d;
      rdata_q    <= rdata_d;
    end
  end

  // Supply-enable pin; a latched fault overrides until software clears it.
  fault_action_type act;
  logic             want_on;
  logic             en_lvl;
  logic             pin_d;
  logic             oe_d;
  assign act     = fault_action_type'(cfg_q[CFG_ACT_LSB +: 2]);
  assign want_on = cfg_q[CFG_AUTO_BIT] ? sess_q : sup_on_q;
  assign en_lvl  = cfg_q[CFG_EN_HIGH_BIT];
  always_comb begin
    pin_d = want_on ? en_lvl : !en_lvl;
    oe_d  = host_q;
    if (stat_q[IRQ_FAULT]) begin
      case (act)
        fault_action_hiz:        oe_d  = 1'b0;
        fault_action_drive_low:  pin_d = 1'b0;
        fault_action_drive_high: pin_d = 1'b1;
        default: ;
      endcase
    end
  end

  logic pin_q;
  logic oe_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q  <= oe_d;
    end
  end

  assign supply_enable_output = pin_q;
  assign supply_enable_oe     = oe_q;
  assign host_mode            = host_q;
  assign reg_rdata            = rdata_q;
  assign irq                  = |(stat_q & mask_q);
endmodule

// >>> tb/hpc_ctrl_monitor.sv
module hpc_ctrl_monitor
  import hpc_pkg::*;
(
  // Clock and reset.
  input wire logic                        core_clk,
  input wire logic                        arst_n,
  // Register port.
  input wire logic [hpc_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [hpc_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [hpc_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic                        irq,
  // Power pins.
  input wire logic                        bus_voltage_low,
  input wire logic                        supply_enable_output,
  input wire logic                        supply_enable_oe,
  input wire logic                        bus_voltage_err,
  // Token path.
  input wire logic                        tok_valid,
  input wire logic [hpc_pkg::EP_W-1:0]    tok_ep,
  input wire logic [hpc_pkg::HUB_W-1:0]   tok_hub,
  input wire logic                        tok_status,
  input wire logic                        pkt_rcvd,
  input wire logic                        host_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Shadow copies of the controls that qualify the checks below.
  logic [CFG_W-1:0]  cfg_q;
  logic [IRQ_W-1:0]  mask_q;
  logic [FILT_W-1:0] dip_q;
  logic              flt_en_q;
  logic              busy_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RESET;
      mask_q <= '0;
      dip_q <= '0;
      flt_en_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_PWRCFG) cfg_q <= reg_wdata[CFG_W-1:0];
      if (reg_wr && reg_addr == OFS_IRQ_MASK) mask_q <= reg_wdata[IRQ_W-1:0];
      if (reg_wr && reg_addr == OFS_PWRCMD && reg_wdata[CMD_FAULT_ON]) flt_en_q <= 1'b1;
      else if (reg_wr && reg_addr == OFS_PWRCMD && reg_wdata[CMD_FAULT_OFF]) flt_en_q <= 1'b0;
      // Saturating, so a very long dip cannot wrap and look short.
      dip_q <= !bus_voltage_low ? '0 : (&dip_q ? dip_q : dip_q + 1'b1);
      if (tok_valid) busy_q <= 1'b1;
      else if (pkt_rcvd) busy_q <= 1'b0;
    end
  end
  // A status request taken while the token path is idle and no request is in flight.
  sequence s_status_req;
    reg_wr && reg_addr == OFS_REQ && reg_wdata[REQ_STATUS_BIT] && host_mode && !busy_q
      && !tok_valid && !$past(reg_wr);
  endsequence
  sequence s_status_tok;
    ##2 tok_valid && tok_status && tok_ep == '0;
  endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_tok_pulse; tok_valid |=> !tok_valid; endproperty
  a_tok_pulse: assert property (p_tok_pulse)
    else $error("token strobe longer than one cycle");
  property p_tok_host; tok_valid |-> host_mode; endproperty
  a_tok_host: assert property (p_tok_host)
    else $error("token issued outside host role");
  property p_stat_ep0; tok_valid && tok_status |-> tok_ep == '0; endproperty
  a_stat_ep0: assert property (p_stat_ep0)
    else $error("status token not on endpoint zero");
  property p_tok_hold; tok_valid |=> $stable(tok_ep) && $stable(tok_hub) && $stable(tok_status);
  endproperty
  a_tok_hold: assert property (p_tok_hold)
    else $error("token fields moved after the strobe");
  property p_status_req; s_status_req |-> s_status_tok; endproperty
  a_status_req: assert property (p_status_req)
    else $error("status request gave no status token");
  property p_pkt_irq;
    pkt_rcvd && busy_q && (tok_status ? mask_q[IRQ_STATUS] : mask_q[IRQ_INDATA])
      |=> irq;
  endproperty
  a_pkt_irq: assert property (p_pkt_irq)
    else $error("received packet raised no interrupt");
  property p_oe_nohost; !host_mode [*2] |-> !supply_enable_oe; endproperty
  a_oe_nohost: assert property (p_oe_nohost)
    else $error("supply pin driven outside host role");
  property p_sup_on;
    reg_wr && reg_addr == OFS_PWRCMD && reg_wdata[CMD_SUPPLY_ON] && host_mode
      && !cfg_q[CFG_AUTO_BIT] && !flt_en_q
      |=> ##[0:2] supply_enable_oe && supply_enable_output == cfg_q[CFG_EN_HIGH_BIT];
  endproperty
  a_sup_on: assert property (p_sup_on)
    else $error("supply enable did not reach its active level");
  property p_nofilt; !cfg_q[CFG_FILTER_BIT] |-> bus_voltage_err == bus_voltage_low; endproperty
  a_nofilt: assert property (p_nofilt)
    else $error("unfiltered voltage error differs from the dip");
  property p_filt;
    bus_voltage_err |-> bus_voltage_low && (!cfg_q[CFG_FILTER_BIT] || dip_q >= FILTER_CYC);
  endproperty
  a_filt: assert property (p_filt)
    else $error("voltage error on a dip shorter than the filter");
endmodule

bind hpc_ctrl hpc_ctrl_monitor mon (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .irq, .bus_voltage_low, .supply_enable_output, .supply_enable_oe,
  .bus_voltage_err, .tok_valid, .tok_ep, .tok_hub, .tok_status, .pkt_rcvd, .host_mode);

// >>> tb/usb_dev_model.sv
module usb_dev_model (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Token from the controller and turnaround choice.
  input  wire logic tok_valid,
  input  wire logic slow,
  // Packet back to the controller.
  output logic      pkt_rcvd
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_q;
  // Answers each token once, after a short or a long turnaround, so both paces are seen.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 0;
      pkt_rcvd <= 1'b0;
    end else begin
      pkt_rcvd <= (wait_q == 1);
      if (tok_valid) wait_q <= slow ? 9 : 2;
      else if (wait_q != 0) wait_q <= wait_q - 1;
    end
  end
endmodule

// >>> tb/usb_host_power_and_request_ctrl_test.sv
module usb_host_power_and_request_ctrl_test
  import hpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              core_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              power_fault_input = 1'b0;
  logic              bus_voltage_low = 1'b0;
  logic              irq, supply_enable_output, supply_enable_oe, bus_voltage_err;
  logic              tok_valid, tok_status, pkt_rcvd, host_mode;
  logic [EP_W-1:0]   tok_ep;
  logic [HUB_W-1:0]  tok_hub;
  logic              slow = 1'b0;
  logic              err_seen = 1'b0;
  int                fail_count = 0;
  int                checks = 0;
  int                tok_n = 0;

  hpc_ctrl uut (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .power_fault_input, .bus_voltage_low, .supply_enable_output, .supply_enable_oe,
    .bus_voltage_err, .tok_valid, .tok_ep, .tok_hub, .tok_status, .pkt_rcvd, .host_mode);
  usb_dev_model dev (.core_clk, .arst_n, .tok_valid, .slow, .pkt_rcvd);

  always #50 core_clk = ~core_clk;
  // Count tokens and remember whether a voltage error was flagged since dip last cleared the flag.
  always @(posedge core_clk) begin
    if (tok_valid === 1'b1) tok_n++;
    if (bus_voltage_err === 1'b1) err_seen <= 1'b1;
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just then.
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic logic [DATA_W-1:0] pins();
    return 32'({supply_enable_oe, supply_enable_output & supply_enable_oe});
  endfunction
  task automatic dip(input int n, input logic exp);
    err_seen = 1'b0;
    @(posedge core_clk);
    bus_voltage_low <= 1'b1;
    repeat (n) @(posedge core_clk);
    bus_voltage_low <= 1'b0;
    cyc(2);
    chk(32'(err_seen), 32'(exp));
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    results();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rd_chk(8'h30, 32'h0);
    // A request before host mode must be dropped.
    wr(OFS_REQ, 32'h81);
    cyc(4);
    chk(32'(tok_n), 32'h0);
    rd_chk(OFS_PEND, 32'h0);
    rd_chk(OFS_MODE, 32'h0);
    wr(OFS_MODE, 32'h1);
    #1 chk(32'(host_mode), 32'h1);
    rd_chk(OFS_MODE, 32'h1);
    for (int e = 0; e < NUM_EP; e++) begin
      wr(OFS_HUB_BASE + 8'(e * 4), 32'(16 + e));
      wr(OFS_HUB_BASE + 8'h20 + 8'(e * 4), 32'(80 + e));
    end
    for (int e = 0; e < NUM_EP; e++) begin
      rd_chk(OFS_HUB_BASE + 8'(e * 4), 32'(16 + e));
      rd_chk(OFS_HUB_BASE + 8'h20 + 8'(e * 4), 32'(80 + e));
    end
    // IN request on endpoint 5 with the interrupt masked at first.
    wr(OFS_REQ, 32'h85);
    cyc(12);
    chk(32'(tok_n), 32'h1);
    chk(32'({tok_status, tok_ep, tok_hub}), 32'h295);
    rd_chk(OFS_IRQ_STAT, 32'h4);
    rd_chk(OFS_REQ, 32'h5);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h7);
    #1 chk(32'(irq), 32'h1);
    rd_chk(OFS_IRQ_MASK, 32'h7);
    wr(OFS_IRQ_STAT, 32'h4);
    #1 chk(32'(irq), 32'h0);
    // Status stage against a slow device.
    slow <= 1'b1;
    wr(OFS_REQ, 32'h100);
    cyc(3);
    chk(32'({tok_status, tok_ep, tok_hub}), 32'h410);
    chk(32'(irq), 32'h0);
    cyc(12);
    chk(32'(irq), 32'h1);
    rd_chk(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    for (int l = 0; l < 2; l++) begin
      wr(OFS_PWRCFG, 32'(l << CFG_EN_HIGH_BIT));
      wr(OFS_PWRCMD, 32'h1);
      cyc(2);
      chk(pins(), 32'(2 + l));
      wr(OFS_PWRCMD, 32'h2);
      cyc(2);
      chk(32'({supply_enable_oe, supply_enable_output}), 32'(3 - l));
    end
    wr(OFS_PWRCFG, 32'h18);
    wr(OFS_PWRCMD, 32'h10);
    cyc(2);
    chk(pins(), 32'h3);
    wr(OFS_PWRCMD, 32'h20);
    cyc(2);
    chk(pins(), 32'h2);
    // Every polarity and fault action; the action must outlast the fault itself.
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 4; a++) begin
        wr(OFS_PWRCMD, 32'h8);
        power_fault_input <= ~p[0];
        wr(OFS_PWRCFG, 32'h10 | 32'(a << 1) | 32'(p));
        wr(OFS_PWRCMD, 32'h5);
        power_fault_input <= p[0];
        cyc(4);
        rd_chk(OFS_IRQ_STAT, 32'h1);
        power_fault_input <= ~p[0];
        cyc(3);
        chk(pins(), 32'({a != 1, a == 0 || a == 3}));
        wr(OFS_IRQ_STAT, 32'h1);
        cyc(3);
        chk(pins(), 32'h3);
      end
    end
    wr(OFS_PWRCMD, 32'h8);
    wr(OFS_PWRCFG, 32'h13);
    power_fault_input <= 1'b1;
    cyc(4);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    chk(pins(), 32'h3);
    rd_chk(OFS_PWRCMD, 32'h1);
    rd_chk(OFS_PWRCFG, 32'h13);
    wr(OFS_PWRCFG, 32'h30);
    dip(FILTER_CYC - 3, 1'b0);
    dip(FILTER_CYC + 2, 1'b1);
    wr(OFS_PWRCFG, 32'h10);
    dip(1, 1'b1);
    results();
  end
endmodule
